// ### dv/it16_interval_timer_checker.sv
// Checker: bus handshake, control readback and interrupt masking at the timer ports
`timescale 1ns/10ps
module it16_interval_timer_checker
  import it16_pkg::*;
(
  input wire logic                     i_ref_clk,     // Clock
  input wire logic                     i_rst_b,       // Reset, active low
  input wire it16_pkg::it16_avmm_req_t i_avmm,        // Bus request
  input wire logic                     o_waitrequest, // Bus wait
  input wire logic [31:0]              o_readdata,    // Bus read data
  input wire it16_pkg::it16_async_in_t i_async,       // Pins, not watched
  input wire logic                     o_irq          // Interrupt
);
  logic        req;
  logic        rd_ctl;
  logic [15:0] ctrl_q;
  assign req    = i_avmm.read | i_avmm.write;
  assign rd_ctl = i_avmm.read & ~o_waitrequest & (i_avmm.address == IT16_OFS_CONTROL);
  // Shadow of the control word; assumes both byte lanes, as the bench always writes
  always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      ctrl_q <= IT16_CTRL_RESET;
    end else if (i_avmm.write && !o_waitrequest && i_avmm.address == IT16_OFS_CONTROL) begin
      ctrl_q <= i_avmm.writedata[15:0];
    end
  end
  a_wait_first: assert property (@(posedge i_ref_clk) disable iff (!i_rst_b)
    $rose(req) |-> o_waitrequest) else $error("no wait state on new request");
  a_wait_one: assert property (@(posedge i_ref_clk) disable iff (!i_rst_b)
    req && o_waitrequest |=> req && !o_waitrequest) else $error("wait state not one cycle");
  a_wait_idle: assert property (@(posedge i_ref_clk) disable iff (!i_rst_b)
    !req |-> !o_waitrequest) else $error("waitrequest without request");
  a_upper_zero: assert property (@(posedge i_ref_clk) disable iff (!i_rst_b)
    o_readdata[31:16] == 16'h0000) else $error("upper read data not zero");
  a_unimpl_zero: assert property (@(posedge i_ref_clk) disable iff (!i_rst_b)
    rd_ctl |-> (o_readdata[15:0] & 16'h4049) == 16'h0000) else $error("reserved bits set");
  a_ctrl_readback: assert property (@(posedge i_ref_clk) disable iff (!i_rst_b)
    rd_ctl |-> (o_readdata[15:0] & IT16_CTRL_WR_MASK) == (ctrl_q & IT16_CTRL_WR_MASK))
    else $error("control readback differs");
  a_pend_quiet: assert property (@(posedge i_ref_clk) disable iff (!i_rst_b)
    rd_ctl && !(ctrl_q[1] && !ctrl_q[2]) |-> o_readdata[11:10] == 2'b00)
    else $error("pending flag outside async mode");
  a_irq_masked: assert property (@(posedge i_ref_clk) disable iff (!i_rst_b)
    i_avmm.write && !o_waitrequest && i_avmm.address == IT16_OFS_IRQ_EN
    && i_avmm.byteenable[0] && i_avmm.writedata[1:0] == 2'b00 |=> !o_irq)
    else $error("irq high with all sources masked");
  a_rdata_hold: assert property (@(posedge i_ref_clk) disable iff (!i_rst_b)
    !(i_avmm.read && o_waitrequest) |=> $stable(o_readdata)) else $error("read data moved");
endmodule : it16_interval_timer_checker

bind it16_interval_timer it16_interval_timer_checker u_chk (
  .i_ref_clk(i_ref_clk), .i_rst_b(i_rst_b), .i_avmm(i_avmm), .o_waitrequest(o_waitrequest),
  .o_readdata(o_readdata), .i_async(i_async), .o_irq(o_irq));

// ### dv/it16_pin_model.sv
// Pin-side model: count pin, gate pin and free-running foreign clocks
`timescale 1ns/10ps
module it16_pin_model (
  input  wire logic i_clk,  // Pacing clock
  output logic      o_pin,  // External count pin, low between bursts
  output logic      o_gate, // Gate pin
  output logic      o_inst, // Instruction clock
  output logic      o_osc,  // Oscillator clock
  output logic      o_frc   // Fast RC clock
);
  initial begin
    o_pin  = 1'b0;
    o_gate = 1'b0;
    o_inst = 1'b0;
    o_osc  = 1'b0;
    o_frc  = 1'b0;
  end
  // Half periods well above the input filter so no edge is swallowed
  always #200 o_inst = ~o_inst;
  always #280 o_osc = ~o_osc;
  always #360 o_frc = ~o_frc;
  task automatic pulse(input int n);
    repeat (n) begin
      repeat (8) @(posedge i_clk);
      o_pin <= 1'b1;
      repeat (8) @(posedge i_clk);
      o_pin <= 1'b0;
    end
    repeat (8) @(posedge i_clk);
  endtask : pulse
  task automatic set_gate(input logic v);
    o_gate <= v;
  endtask : set_gate
endmodule : it16_pin_model

// ### dv/tb_interval_timer_16bit.sv
// Testbench: registers, prescaler, period interrupt, gating and external counting
`timescale 1ns/10ps
module tb_interval_timer_16bit;
  import it16_pkg::*;
  localparam logic [15:0] ON = 16'h8000;
  localparam logic [15:0] CS = 16'h0002;
  localparam logic [15:0] SY = 16'h0004;
  logic           clk;
  logic           rst_b;
  it16_avmm_req_t req;
  it16_async_in_t asy;
  logic           wreq;
  logic [31:0]    rdata;
  logic           irq;
  logic           pin, gate, inst, osc, fast_rc_clock;
  logic           idle;
  logic           sleep;
  logic [31:0]    q;
  logic [3:0]     be = 4'h3;
  logic [15:0]    wd_hi = 16'h0000;
  int             err_total;
  int             total_checks;
  int             cyc = 0;
  assign asy = '{ext_clk_pin: pin, inst_clk: inst, osc_clk: osc, frc_clk: fast_rc_clock,
                 gate: gate, idle: idle, sleep: sleep};
  it16_interval_timer dut (.i_ref_clk(clk), .i_rst_b(rst_b), .i_avmm(req),
    .o_waitrequest(wreq), .o_readdata(rdata), .i_async(asy), .o_irq(irq));
  it16_pin_model u_pins (.i_clk(clk), .o_pin(pin), .o_gate(gate), .o_inst(inst),
    .o_osc(osc), .o_frc(fast_rc_clock));
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  task automatic fail(input string m);
    err_total++;
    $display("MISMATCH %0t %s", $time, m);
  endtask : fail
  task automatic chk(input logic [15:0] g, input logic [15:0] lo, input logic [15:0] hi,
                     input string m);
    total_checks++;
    if (^g === 1'bx || g < lo || g > hi) fail(m);
  endtask : chk
  // One idle edge first, so a release and a new request never share a time step
  task automatic bus(input logic w, input logic [7:0] a, input logic [15:0] d);
    @(posedge clk);
    req <= '{read: !w, write: w, address: a, byteenable: be, writedata: {wd_hi, d}};
    @(posedge clk);
    while (wreq !== 1'b0) @(posedge clk);
    q = rdata;
    req <= '0;
  endtask : bus
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    bus(1'b1, a, d);
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [15:0] lo, input logic [15:0] hi,
                    input string m);
    bus(1'b0, a, 16'h0000);
    chk(q[15:0], lo, hi, m);
  endtask : rd
  task automatic t_reset();
    rd(IT16_OFS_CONTROL, 16'h0000, 16'h0000, "control reset");
    rd(IT16_OFS_COUNT, 16'h0000, 16'h0000, "count reset");
    rd(IT16_OFS_PERIOD, 16'hffff, 16'hffff, "period reset");
    rd(IT16_OFS_IRQ_STAT, 16'h0000, 16'h0000, "status reset");
    wr(8'h18, 16'h5a5a);
    rd(8'h18, 16'h0000, 16'h0000, "unmapped");
    wr(IT16_OFS_CONTROL, 16'hffff);
    rd(IT16_OFS_CONTROL, 16'hb3b6, 16'hb3b6, "control mask");
    wr(IT16_OFS_CONTROL, 16'h0000);
    be = 4'h1;
    wr(IT16_OFS_PERIOD, 16'h1234);
    rd(IT16_OFS_PERIOD, 16'hff34, 16'hff34, "low lane");
    be = 4'h2;
    wr(IT16_OFS_IRQ_EN, 16'h0003);
    rd(IT16_OFS_IRQ_EN, 16'h0000, 16'h0000, "lane 0 off");
    wr(IT16_OFS_PERIOD, 16'h5678);
    rd(IT16_OFS_PERIOD, 16'h5634, 16'h5634, "high lane");
    be = 4'hf;
    wd_hi = 16'hffff;
    wr(IT16_OFS_PERIOD, 16'hffff);
    rd(IT16_OFS_PERIOD, 16'hffff, 16'hffff, "upper ignored");
    be = 4'h3;
    wd_hi = 16'h0000;
  endtask : t_reset
  task automatic t_prescale();
    int dv[4] = '{1, 8, 64, 256};
    for (int p = 0; p < 4; p++) begin
      wr(IT16_OFS_COUNT, 16'h0000);
      wr(IT16_OFS_CONTROL, ON | 16'(p << 4));
      repeat (10 * dv[p]) @(posedge clk);
      wr(IT16_OFS_CONTROL, 16'h0000);
      rd(IT16_OFS_COUNT, 16'h000a, 16'h000e, "prescaled count");
    end
  endtask : t_prescale
  task automatic t_period();
    int n;
    wr(IT16_OFS_PERIOD, 16'h0005);
    wr(IT16_OFS_COUNT, 16'h0000);
    wr(IT16_OFS_IRQ_EN, 16'h0001);
    wr(IT16_OFS_CONTROL, ON);
    for (n = 0; n < 40 && irq !== 1'b1; n++) @(posedge clk);
    chk(16'(n), 16'h0004, 16'h0009, "period irq time");
    wr(IT16_OFS_CONTROL, 16'h0000);
    rd(IT16_OFS_COUNT, 16'h0000, 16'h0005, "count wrapped");
    wr(IT16_OFS_IRQ_EN, 16'h0000);
    rd(IT16_OFS_IRQ_STAT, 16'h0001, 16'h0001, "period flag");
    chk({15'h0000, irq}, 16'h0000, 16'h0000, "masked irq");
    wr(IT16_OFS_IRQ_EN, 16'h0001);
    rd(IT16_OFS_IRQ_EN, 16'h0001, 16'h0001, "enable readback");
    chk({15'h0000, irq}, 16'h0001, 16'h0001, "irq level");
    wr(IT16_OFS_IRQ_CLR, 16'h0001);
    rd(IT16_OFS_IRQ_STAT, 16'h0000, 16'h0000, "flag cleared");
    chk({15'h0000, irq}, 16'h0000, 16'h0000, "irq cleared");
    wr(IT16_OFS_PERIOD, 16'hffff);
  endtask : t_period
  task automatic t_gate();
    wr(IT16_OFS_COUNT, 16'h0000);
    wr(IT16_OFS_CONTROL, ON | 16'h0080);
    repeat (40) @(posedge clk);
    rd(IT16_OFS_COUNT, 16'h0000, 16'h0000, "gate low holds");
    u_pins.set_gate(1'b1);
    repeat (100) @(posedge clk);
    u_pins.set_gate(1'b0);
    repeat (10) @(posedge clk);
    rd(IT16_OFS_COUNT, 16'h005e, 16'h0068, "gated count");
    rd(IT16_OFS_IRQ_STAT, 16'h0002, 16'h0002, "gate end flag");
    wr(IT16_OFS_CONTROL, 16'h0000);
    wr(IT16_OFS_IRQ_CLR, 16'h0003);
  endtask : t_gate
  task automatic t_ext();
    int hp[3] = '{5, 7, 9};
    wr(IT16_OFS_COUNT, 16'h0000);
    wr(IT16_OFS_CONTROL, ON | CS | SY);
    u_pins.pulse(5);
    rd(IT16_OFS_COUNT, 16'h0005, 16'h0005, "sync edges");
    wr(IT16_OFS_COUNT, 16'h1234);
    rd(IT16_OFS_COUNT, 16'h0005, 16'h0005, "count write ignored");
    wr(IT16_OFS_CONTROL, ON | CS | SY | 16'h0010);
    u_pins.pulse(16);
    rd(IT16_OFS_COUNT, 16'h0007, 16'h0007, "prescaled edges");
    for (int s = 1; s < 4; s++) begin
      wr(IT16_OFS_CONTROL, 16'h0000);
      wr(IT16_OFS_COUNT, 16'h0000);
      wr(IT16_OFS_CONTROL, ON | CS | SY | 16'(s << 8));
      repeat (100) @(posedge clk);
      wr(IT16_OFS_CONTROL, 16'h0000);
      rd(IT16_OFS_COUNT, 16'(50 / hp[s - 1] - 1), 16'(50 / hp[s - 1] + 2), "source");
    end
  endtask : t_ext
  task automatic t_async();
    logic [15:0] c0;
    wr(IT16_OFS_COUNT, 16'h0000);
    wr(IT16_OFS_CONTROL, ON | CS | 16'h1000);
    wr(IT16_OFS_COUNT, 16'h0100);
    rd(IT16_OFS_CONTROL, 16'h9802, 16'h9802, "count pending");
    wr(IT16_OFS_COUNT, 16'h0200);
    u_pins.pulse(1);
    rd(IT16_OFS_CONTROL, 16'h9002, 16'h9002, "count done");
    rd(IT16_OFS_COUNT, 16'h0100, 16'h0101, "second write dropped");
    wr(IT16_OFS_PERIOD, 16'h0050);
    rd(IT16_OFS_CONTROL, 16'h9402, 16'h9402, "period pending");
    u_pins.pulse(1);
    rd(IT16_OFS_PERIOD, 16'h0050, 16'h0050, "period posted");
    bus(1'b0, IT16_OFS_COUNT, 16'h0000);
    c0 = q[15:0];
    sleep <= 1'b1;
    u_pins.pulse(3);
    sleep <= 1'b0;
    rd(IT16_OFS_COUNT, c0 + 16'h0003, c0 + 16'h0003, "counts in sleep");
    wr(IT16_OFS_CONTROL, 16'h0000);
    wr(IT16_OFS_PERIOD, 16'hffff);
  endtask : t_async
  task automatic t_idle();
    idle <= 1'b1;
    wr(IT16_OFS_COUNT, 16'h0000);
    wr(IT16_OFS_CONTROL, ON | 16'h2000);
    repeat (50) @(posedge clk);
    rd(IT16_OFS_COUNT, 16'h0000, 16'h0000, "idle stop");
    idle <= 1'b0;
    repeat (20) @(posedge clk);
    rd(IT16_OFS_COUNT, 16'h000a, 16'h0030, "idle resume");
    wr(IT16_OFS_CONTROL, 16'h0000);
  endtask : t_idle
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : tally_and_finish
  // Whole sequence needs about 4500 cycles; the ceiling leaves ample margin
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 40000) begin
      fail("timeout");
      tally_and_finish();
    end
  end
  initial begin
    rst_b = 1'b0;
    req = '0;
    idle = 1'b0;
    sleep = 1'b0;
    err_total = 0;
    total_checks = 0;
    repeat (12) @(posedge clk);
    rst_b <= 1'b1;
    t_reset();
    $display("reset test done");
    t_prescale();
    $display("prescale test done");
    t_period();
    $display("period test done");
    t_gate();
    $display("gate test done");
    t_ext();
    $display("external test done");
    t_async();
    $display("async test done");
    t_idle();
    $display("idle test done");
    tally_and_finish();
  end
endmodule : tb_interval_timer_16bit

// ### hdl/it16_interval_timer.sv
// Module: 16-bit interval timer/counter with Avalon-MM register slave and interrupt
// Summary of operation
// - 16-bit free-running timer: plain, gated, synchronous and asynchronous counter modes
// - Timer on bit 15 starts counting when set, stops when clear
// - Idle stop bit 13 halts timer in Idle; clear keeps it running
// - Async write disable bit 12 drops timer writes while a posted write pends
// - Read-only bit 11 shows a pending asynchronous count write
// - Read-only bit 10 shows a pending asynchronous period write
// - Bits 9-8 pick external source: fast RC, oscillator, instruction clock, pin
// - Clock source bit 1 selects external source, else peripheral clock
// - Gate enable bit 7 gates accumulation on internal clock; ignored on external
// - Prescale bits 5-4 divide by 256, 64, 8 or 1
// - Sync select bit 2 synchronises external input; ignored on internal clock
// - External input is synchronised after the prescaler, not before
// - Count writes ignored while running as external synchronous counter
// - Asynchronous counter keeps running while the CPU sleeps
// - Unimplemented control bits 14, 6, 3 and 0 read as zero
`timescale 1ns/10ps
module it16_interval_timer
  import it16_pkg::*;
(
  input  wire logic                     i_ref_clk,      // 25 MHz peripheral clock
  input  wire logic                     i_rst_b,        // Async reset, active low
  input  wire it16_pkg::it16_avmm_req_t i_avmm,         // Avalon-MM request
  output logic                          o_waitrequest,  // Avalon-MM waitrequest
  output logic [31:0]                   o_readdata,     // Avalon-MM read data
  input  wire it16_pkg::it16_async_in_t i_async,        // Pins and foreign clocks
  output logic                          o_irq           // Level interrupt
);

  // ---------------------------------------------------------------------
  // Input conditioning: three flops, a change counts once stages 2 and 3 agree
  // ---------------------------------------------------------------------
  localparam int NIN = $bits(it16_async_in_t);

  logic [NIN-1:0] sync1_q;
  logic [NIN-1:0] sync2_q;
  logic [NIN-1:0] sync3_q;
  logic [NIN-1:0] clean_q;
  it16_async_in_t in_c;

  always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      sync1_q <= '0;
      sync2_q <= '0;
      sync3_q <= '0;
    end else begin
      sync1_q <= i_async;
      sync2_q <= sync1_q;
      sync3_q <= sync2_q;
    end
  end

  genvar gi;
  generate
    for (gi = 0; gi < NIN; gi++) begin : g_filter
      always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
          clean_q[gi] <= 1'b0;
        end else if (sync2_q[gi] == sync3_q[gi]) begin
          clean_q[gi] <= sync3_q[gi];
        end
      end
    end
  endgenerate

  assign in_c = clean_q;

  // ---------------------------------------------------------------------
  // Registers
  // ---------------------------------------------------------------------
  logic [15:0]          ctrl_q;
  logic [15:0]          count_q;
  logic [15:0]          period_q;
  logic [IT16_IRQ_W-1:0] irq_stat_q;
  logic [IT16_IRQ_W-1:0] irq_en_q;
  logic                 cnt_pend_q;
  logic                 per_pend_q;
  logic [15:0]          cnt_post_q;
  logic [15:0]          per_post_q;

  logic       timer_on;
  logic       idle_stop;
  logic       async_wr_dis;
  logic [1:0] ext_sel;
  logic       gate_en;
  logic [1:0] presc_sel;
  logic       sync_sel;
  logic       clk_src;

  assign timer_on     = ctrl_q[IT16_BIT_TIMER_ON];
  assign idle_stop    = ctrl_q[IT16_BIT_IDLE_STOP];
  assign async_wr_dis = ctrl_q[IT16_BIT_ASYNC_WR_DIS];
  assign ext_sel      = ctrl_q[IT16_BIT_EXT_SEL_HI:IT16_BIT_EXT_SEL_LO];
  assign gate_en      = ctrl_q[IT16_BIT_GATE_EN];
  assign presc_sel    = ctrl_q[IT16_BIT_PRESC_HI:IT16_BIT_PRESC_LO];
  assign sync_sel     = ctrl_q[IT16_BIT_SYNC_SEL];
  assign clk_src      = ctrl_q[IT16_BIT_CLK_SRC];

  // Asynchronous counter: external source without synchronisation
  logic async_mode;
  logic ext_sync_run;
  assign async_mode   = clk_src && !sync_sel;
  assign ext_sync_run = clk_src && sync_sel && timer_on;

  function automatic logic [7:0] presc_tc(input logic [1:0] sel);
    case (sel)
      IT16_PS_DIV1:   presc_tc = IT16_TC_DIV1;
      IT16_PS_DIV8:   presc_tc = IT16_TC_DIV8;
      IT16_PS_DIV64:  presc_tc = IT16_TC_DIV64;
      IT16_PS_DIV256: presc_tc = IT16_TC_DIV256;
      default:        presc_tc = IT16_TC_DIV1;
    endcase
  endfunction : presc_tc

  function automatic logic [31:0] ctrl_view(input logic [15:0] c,
                                            input logic        cp,
                                            input logic        pp);
    logic [15:0] v;
    v = c & IT16_CTRL_WR_MASK;
    v[IT16_BIT_CNT_WR_PEND] = cp;
    v[IT16_BIT_PER_WR_PEND] = pp;
    ctrl_view = {16'h0000, v};
  endfunction : ctrl_view

  // ---------------------------------------------------------------------
  // Avalon-MM slave: one wait state, write lands at the edge waitrequest is low
  // ---------------------------------------------------------------------
  logic ack_q;
  logic req;
  logic wr_go;
  logic rd_go;
  assign req           = i_avmm.read || i_avmm.write;
  assign o_waitrequest = req && !ack_q;
  assign wr_go         = i_avmm.write && ack_q;
  assign rd_go         = i_avmm.read && !ack_q;

  always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      ack_q <= 1'b0;
    end else begin
      ack_q <= req && !ack_q;
    end
  end

  // Only the low two byte lanes hold data; upper lanes are ignored
  logic [15:0] wdata16;
  logic [15:0] be_mask;
  assign be_mask = {{8{i_avmm.byteenable[1]}}, {8{i_avmm.byteenable[0]}}};

  function automatic logic [15:0] merge16(input logic [15:0] old,
                                          input logic [15:0] nw,
                                          input logic [15:0] m);
    merge16 = (old & ~m) | (nw & m);
  endfunction : merge16

  assign wdata16 = i_avmm.writedata[15:0];

  logic wr_ctrl;
  logic wr_count;
  logic wr_period;
  logic wr_irq_clr;
  logic wr_irq_en;
  assign wr_ctrl    = wr_go && (i_avmm.address == IT16_OFS_CONTROL);
  assign wr_count   = wr_go && (i_avmm.address == IT16_OFS_COUNT);
  assign wr_period  = wr_go && (i_avmm.address == IT16_OFS_PERIOD);
  assign wr_irq_clr = wr_go && (i_avmm.address == IT16_OFS_IRQ_CLR);
  assign wr_irq_en  = wr_go && (i_avmm.address == IT16_OFS_IRQ_EN);

  always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      o_readdata <= 32'h0000_0000;
    end else if (rd_go) begin
      case (i_avmm.address)
        IT16_OFS_CONTROL:  o_readdata <= ctrl_view(ctrl_q, cnt_pend_q, per_pend_q);
        IT16_OFS_COUNT:    o_readdata <= {16'h0000, count_q};
        IT16_OFS_PERIOD:   o_readdata <= {16'h0000, period_q};
        IT16_OFS_IRQ_STAT: o_readdata <= {{(32-IT16_IRQ_W){1'b0}}, irq_stat_q};
        IT16_OFS_IRQ_EN:   o_readdata <= {{(32-IT16_IRQ_W){1'b0}}, irq_en_q};
        default:           o_readdata <= 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      ctrl_q <= IT16_CTRL_RESET;
    end else if (wr_ctrl) begin
      ctrl_q <= merge16(ctrl_q, wdata16, be_mask) & IT16_CTRL_WR_MASK;
    end
  end

  always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      irq_en_q <= '0;
    end else if (wr_irq_en && i_avmm.byteenable[0]) begin
      irq_en_q <= wdata16[IT16_IRQ_W-1:0];
    end
  end

  // ---------------------------------------------------------------------
  // Clock source selection and prescaler
  // ---------------------------------------------------------------------
  logic ext_src;
  always_comb begin
    case (ext_sel)
      IT16_EXT_PIN:  ext_src = in_c.ext_clk_pin;
      IT16_EXT_INST: ext_src = in_c.inst_clk;
      IT16_EXT_OSC:  ext_src = in_c.osc_clk;
      IT16_EXT_FRC:  ext_src = in_c.frc_clk;
      default:       ext_src = in_c.ext_clk_pin;
    endcase
  end

  logic ext_prev_q;
  logic ext_edge;
  always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      ext_prev_q <= 1'b0;
    end else begin
      ext_prev_q <= ext_src;
    end
  end
  assign ext_edge = ext_src && !ext_prev_q;

  // The internal clock and synchronous modes stop in sleep; only the
  // asynchronous counter keeps its source alive there.
  logic halted;
  logic gate_ok;
  logic src_pulse;
  assign halted  = (in_c.idle && idle_stop)
                || (in_c.sleep && !async_mode);
  assign gate_ok = clk_src || !gate_en || in_c.gate;
  assign src_pulse = clk_src ? ext_edge : 1'b1;

  logic       presc_en;
  logic [7:0] presc_q;
  logic       presc_tick;
  assign presc_en   = timer_on && !halted && gate_ok && src_pulse;
  assign presc_tick = presc_en && (presc_q == presc_tc(presc_sel));

  always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      presc_q <= 8'h00;
    end else if (!timer_on || wr_ctrl || wr_count) begin
      presc_q <= 8'h00;
    end else if (presc_en) begin
      presc_q <= presc_tick ? 8'h00 : presc_q + 8'h01;
    end
  end

  // Synchronisation sits behind the prescaler: its tick is carried as a
  // toggle through three flops, which costs three cycles of latency.
  logic tick_tgl_q;
  logic tick_s1_q;
  logic tick_s2_q;
  logic tick_s3_q;
  logic sync_tick;
  always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      tick_tgl_q <= 1'b0;
      tick_s1_q  <= 1'b0;
      tick_s2_q  <= 1'b0;
      tick_s3_q  <= 1'b0;
    end else begin
      if (presc_tick) begin
        tick_tgl_q <= !tick_tgl_q;
      end
      tick_s1_q <= tick_tgl_q;
      tick_s2_q <= tick_s1_q;
      tick_s3_q <= tick_s2_q;
    end
  end
  assign sync_tick = tick_s2_q ^ tick_s3_q;

  logic count_tick;
  always_comb begin
    if (clk_src && sync_sel) begin
      count_tick = sync_tick && timer_on && !halted;
    end else begin
      count_tick = presc_tick;
    end
  end

  // ---------------------------------------------------------------------
  // Posted writes in asynchronous mode
  // ---------------------------------------------------------------------
  logic any_pend;
  logic wr_blocked;
  logic post_commit;
  assign any_pend    = cnt_pend_q || per_pend_q;
  assign wr_blocked  = async_mode && async_wr_dis && any_pend;
  // A posted word lands on the next edge of the asynchronous source
  assign post_commit = ext_edge || !async_mode;

  logic cnt_accept;
  logic per_accept;
  assign cnt_accept = wr_count && !ext_sync_run && !wr_blocked;
  assign per_accept = wr_period && !wr_blocked;

  always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      cnt_pend_q <= 1'b0;
      cnt_post_q <= IT16_COUNT_RESET;
    end else if (cnt_accept && async_mode) begin
      cnt_pend_q <= 1'b1;
      cnt_post_q <= merge16(cnt_pend_q ? cnt_post_q : count_q, wdata16, be_mask);
    end else if (cnt_pend_q && post_commit) begin
      cnt_pend_q <= 1'b0;
    end
  end

  always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      per_pend_q <= 1'b0;
      per_post_q <= IT16_PERIOD_RESET;
    end else if (per_accept && async_mode) begin
      per_pend_q <= 1'b1;
      per_post_q <= merge16(per_pend_q ? per_post_q : period_q, wdata16, be_mask);
    end else if (per_pend_q && post_commit) begin
      per_pend_q <= 1'b0;
    end
  end

  always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      period_q <= IT16_PERIOD_RESET;
    end else if (per_accept && !async_mode) begin
      period_q <= merge16(period_q, wdata16, be_mask);
    end else if (per_pend_q && post_commit) begin
      period_q <= per_post_q;
    end
  end

  // ---------------------------------------------------------------------
  // Counter and period match
  // ---------------------------------------------------------------------
  logic period_hit;
  assign period_hit = count_tick && (count_q == period_q);

  always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      count_q <= IT16_COUNT_RESET;
    end else if (cnt_accept && !async_mode) begin
      count_q <= merge16(count_q, wdata16, be_mask);
    end else if (cnt_pend_q && post_commit) begin
      count_q <= cnt_post_q;
    end else if (period_hit) begin
      count_q <= IT16_COUNT_RESET;
    end else if (count_tick) begin
      count_q <= count_q + 16'h0001;
    end
  end

  // ---------------------------------------------------------------------
  // Interrupts: sticky status, set wins over a same-cycle clear
  // ---------------------------------------------------------------------
  logic gate_prev_q;
  logic gate_fall;
  always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      gate_prev_q <= 1'b0;
    end else begin
      gate_prev_q <= in_c.gate;
    end
  end
  // End of a gated accumulation window
  assign gate_fall = timer_on && !clk_src && gate_en && gate_prev_q && !in_c.gate;

  logic [IT16_IRQ_W-1:0] irq_set;
  logic [IT16_IRQ_W-1:0] irq_clr;
  always_comb begin
    irq_set = '0;
    irq_set[IT16_IRQ_PERIOD] = period_hit;
    irq_set[IT16_IRQ_GATE]   = gate_fall;
    irq_clr = (wr_irq_clr && i_avmm.byteenable[0]) ? wdata16[IT16_IRQ_W-1:0] : '0;
  end

  always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      irq_stat_q <= '0;
    end else begin
      irq_stat_q <= (irq_stat_q & ~irq_clr) | irq_set;
    end
  end

  assign o_irq = |(irq_stat_q & irq_en_q);

endmodule : it16_interval_timer

// ### hdl/it16_pkg.sv
// Package: register map, control field layout and shared types of the interval timer
package it16_pkg;

  // Register byte offsets on the Avalon-MM slave
  localparam logic [7:0] IT16_OFS_CONTROL  = 8'h00;
  localparam logic [7:0] IT16_OFS_COUNT    = 8'h04;
  localparam logic [7:0] IT16_OFS_PERIOD   = 8'h08;
  localparam logic [7:0] IT16_OFS_IRQ_STAT = 8'h0c;
  localparam logic [7:0] IT16_OFS_IRQ_CLR  = 8'h10;
  localparam logic [7:0] IT16_OFS_IRQ_EN   = 8'h14;

  // Control register field positions
  localparam int IT16_BIT_TIMER_ON     = 15;
  localparam int IT16_BIT_IDLE_STOP    = 13;
  localparam int IT16_BIT_ASYNC_WR_DIS = 12;
  localparam int IT16_BIT_CNT_WR_PEND  = 11;
  localparam int IT16_BIT_PER_WR_PEND  = 10;
  localparam int IT16_BIT_EXT_SEL_HI   = 9;
  localparam int IT16_BIT_EXT_SEL_LO   = 8;
  localparam int IT16_BIT_GATE_EN      = 7;
  localparam int IT16_BIT_PRESC_HI     = 5;
  localparam int IT16_BIT_PRESC_LO     = 4;
  localparam int IT16_BIT_SYNC_SEL     = 2;
  localparam int IT16_BIT_CLK_SRC      = 1;

  // Software-writable control bits; the rest read back as zero or status
  localparam logic [15:0] IT16_CTRL_WR_MASK = 16'hb3b6;
  localparam logic [15:0] IT16_CTRL_RESET   = 16'h0000;
  localparam logic [15:0] IT16_COUNT_RESET  = 16'h0000;
  localparam logic [15:0] IT16_PERIOD_RESET = 16'hffff;

  // Interrupt status bit positions
  localparam int IT16_IRQ_PERIOD = 0;
  localparam int IT16_IRQ_GATE   = 1;
  localparam int IT16_IRQ_W      = 2;

  // Prescale select encodings and their terminal counts (divide minus one)
  localparam logic [1:0] IT16_PS_DIV1   = 2'b00;
  localparam logic [1:0] IT16_PS_DIV8   = 2'b01;
  localparam logic [1:0] IT16_PS_DIV64  = 2'b10;
  localparam logic [1:0] IT16_PS_DIV256 = 2'b11;
  localparam logic [7:0] IT16_TC_DIV1   = 8'h00;
  localparam logic [7:0] IT16_TC_DIV8   = 8'h07;
  localparam logic [7:0] IT16_TC_DIV64  = 8'h3f;
  localparam logic [7:0] IT16_TC_DIV256 = 8'hff;

  // Extended clock select encodings
  localparam logic [1:0] IT16_EXT_PIN  = 2'b00;
  localparam logic [1:0] IT16_EXT_INST = 2'b01;
  localparam logic [1:0] IT16_EXT_OSC  = 2'b10;
  localparam logic [1:0] IT16_EXT_FRC  = 2'b11;

  typedef struct packed {
    logic        read;
    logic        write;
    logic [7:0]  address;
    logic [3:0]  byteenable;
    logic [31:0] writedata;
  } it16_avmm_req_t;

  typedef struct packed {
    logic ext_clk_pin;
    logic inst_clk;
    logic osc_clk;
    logic frc_clk;
    logic gate;
    logic idle;
    logic sleep;
  } it16_async_in_t;

endpackage : it16_pkg
